// [flash_array_controller.sv]
// unlock sequencer, protection checks and access port of the program memory
// Operation
// - array of 8192/4096/2048/1024 bytes, read/write/erase
// - 512-byte pages, page is smallest erase
// - each page holds eight rows of 64
// - sectors 1024 bytes at 8K, else 512
// - per-sector write protect plus read protect
// - lowest two bytes are option bits
// - core or debugger may program and erase
// - bad value or order relocks controller
// - control write and status read share address
`timescale 1ns/1ps
module flash_array_controller #(
    parameter int MEM_BYTES = 8192,
    parameter int AW        = $clog2(MEM_BYTES),
    parameter int SECT_BYTES = (MEM_BYTES == flash_ctl_pkg::BIG_MEM_BYTES)
                             ? flash_ctl_pkg::BIG_SECT
                             : flash_ctl_pkg::SMALL_SECT,
    parameter int NUM_SECT  = MEM_BYTES / SECT_BYTES,
    parameter int SW        = (NUM_SECT > 1) ? $clog2(NUM_SECT) : 1,
    parameter int PW        = AW - flash_ctl_pkg::PAGE_SHIFT
) (
    input  wire logic                I_SYS_CLK,
    input  wire logic                I_RST,
    input  wire logic                I_CTL_WR,
    input  wire logic [7:0]          I_CTL_WDATA,
    input  wire logic                I_FROM_DBG,
    input  wire logic                I_MEM_RD,
    input  wire logic                I_MEM_PROG,
    input  wire logic [AW-1:0]       I_MEM_ADDR,
    input  wire logic [7:0]          I_MEM_WDATA,
    input  wire logic [NUM_SECT-1:0] I_SECT_WP,
    input  wire logic                I_READ_PROT,
    output logic      [7:0]          O_STATUS,
    output logic      [7:0]          O_MEM_RDATA,
    output logic      [15:0]         O_OPT_BITS,
    output logic      [2:0]          O_PROG_ROW
);
    localparam int SECT_SHIFT = $clog2(SECT_BYTES);

    typedef struct packed {
        flash_ctl_pkg::seq_e state;
        logic [PW-1:0]       page;
        logic                refused;
        logic [7:0]          status;
        logic [7:0]          rdata;
        logic [15:0]         opt;
        logic [2:0]          row;
    } ctl_s;

    ctl_s cur;
    ctl_s next_cur;

    logic [7:0]    arr_rdata;
    logic [15:0]   arr_opt;
    logic [SW-1:0] sect;
    logic [PW-1:0] addr_page;
    logic          sect_locked;
    logic          dbg_blocked;
    logic          prog_ok;
    logic          erase_go;

    // sector and page of the presented address
    assign sect = (NUM_SECT > 1)
                ? SW'(I_MEM_ADDR >> SECT_SHIFT) : '0;
    assign addr_page = PW'(I_MEM_ADDR >> flash_ctl_pkg::PAGE_SHIFT);
    assign sect_locked = I_SECT_WP[sect];
    // debugger is shut out while read protection holds
    assign dbg_blocked = I_FROM_DBG && I_READ_PROT;
    // program only while unlocked and the sector is open
    assign prog_ok = (cur.state == flash_ctl_pkg::UNLOCKED)
                  && I_MEM_PROG && !sect_locked
                  && !dbg_blocked;
    assign erase_go = (cur.state == flash_ctl_pkg::ERASING);

    flash_cell_array #(
        .MEM_BYTES (MEM_BYTES),
        .AW        (AW),
        .PW        (PW)
    ) u_cells (
        .clk     (I_SYS_CLK),
        .i_prog  (prog_ok),
        .i_erase (erase_go),
        .i_addr  (I_MEM_ADDR),
        .i_page  (cur.page),
        .i_wdata (I_MEM_WDATA),
        .o_rdata (arr_rdata),
        .o_opt   (arr_opt)
    );

    // sequencer, read path and status image
    always_comb begin
        next_cur = cur;
        unique case (cur.state)
            flash_ctl_pkg::LOCKED: begin
                if (I_CTL_WR && I_CTL_WDATA == flash_ctl_pkg::KEY_FIRST) begin
                    next_cur.state = flash_ctl_pkg::KEY_SEEN;
                end
            end
            flash_ctl_pkg::KEY_SEEN: begin
                // anything but the second key drops back
                if (I_CTL_WR) begin
                    next_cur.state = (I_CTL_WDATA == flash_ctl_pkg::KEY_SECOND)
                                   ? flash_ctl_pkg::UNLOCKED
                                   : flash_ctl_pkg::LOCKED;
                end
            end
            flash_ctl_pkg::UNLOCKED: begin
                if (I_CTL_WR) begin
                    next_cur.state = flash_ctl_pkg::LOCKED;
                    if (I_CTL_WDATA == flash_ctl_pkg::CMD_PAGE_ERASE) begin
                        if (sect_locked || dbg_blocked) begin
                            next_cur.refused = 1'b1;
                        end else begin
                            next_cur.state = flash_ctl_pkg::ERASING;
                            next_cur.page  = addr_page;
                        end
                    end
                end else if (I_MEM_PROG && !prog_ok) begin
                    next_cur.refused = 1'b1;
                end
            end
            flash_ctl_pkg::ERASING: begin
                // one-cycle erase, then relock against stray commands
                next_cur.state = flash_ctl_pkg::LOCKED;
            end
        endcase
        // a new unlock clears the old refusal
        if (cur.state == flash_ctl_pkg::KEY_SEEN && next_cur.state
            == flash_ctl_pkg::UNLOCKED) begin
            next_cur.refused = 1'b0;
        end
        if (prog_ok) begin
            next_cur.row = I_MEM_ADDR[flash_ctl_pkg::ROW_SHIFT
                           +: flash_ctl_pkg::ROW_W];
        end
        if (I_MEM_RD) begin
            next_cur.rdata = dbg_blocked ? flash_ctl_pkg::ZERO_BYTE
                                         : arr_rdata;
        end
        next_cur.opt = arr_opt;
        // status is what a read of the shared control address returns
        next_cur.status = flash_ctl_pkg::ZERO_BYTE;
        next_cur.status[flash_ctl_pkg::ST_UNLOCKED] =
            (next_cur.state == flash_ctl_pkg::UNLOCKED);
        next_cur.status[flash_ctl_pkg::ST_KEY_SEEN] =
            (next_cur.state == flash_ctl_pkg::KEY_SEEN);
        next_cur.status[flash_ctl_pkg::ST_ERASING] =
            (next_cur.state == flash_ctl_pkg::ERASING);
        next_cur.status[flash_ctl_pkg::ST_REFUSED] = next_cur.refused;
        next_cur.status[flash_ctl_pkg::ST_RD_PROT] = I_READ_PROT;
    end

    // array contents survive reset; only control state is cleared
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            cur.state   <= flash_ctl_pkg::LOCKED;
            cur.page    <= '0;
            cur.refused <= 1'b0;
            cur.status  <= flash_ctl_pkg::ZERO_BYTE;
            cur.rdata   <= flash_ctl_pkg::ZERO_BYTE;
            cur.opt     <= '0;
            cur.row     <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign O_STATUS    = cur.status;
    assign O_MEM_RDATA = cur.rdata;
    assign O_OPT_BITS  = cur.opt;
    assign O_PROG_ROW  = cur.row;

    a_wrong_key_locks: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (cur.state == flash_ctl_pkg::KEY_SEEN && I_CTL_WR
         && I_CTL_WDATA != flash_ctl_pkg::KEY_SECOND)
        |=> O_STATUS[flash_ctl_pkg::ST_UNLOCKED] == 1'b0
            && cur.state == flash_ctl_pkg::LOCKED)
        else $error("wrong second key did not relock");

    a_key_order: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (cur.state == flash_ctl_pkg::LOCKED && I_CTL_WR
         && I_CTL_WDATA == flash_ctl_pkg::KEY_SECOND)
        |=> cur.state == flash_ctl_pkg::LOCKED)
        else $error("second key alone unlocked");

    a_prot_sector_refused: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_MEM_PROG && sect_locked) |-> !prog_ok ##1
        (cur.state != flash_ctl_pkg::UNLOCKED
         || O_STATUS[flash_ctl_pkg::ST_REFUSED]))
        else $error("program into protected sector");

    // a single erase cycle, after which the sequencer is locked again
    a_erase_one_page: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        $rose(erase_go)
        |=> !erase_go && cur.state == flash_ctl_pkg::LOCKED)
        else $error("erase lasted beyond one cycle");

    // cells power up unknown in simulation, so the mirror is checked
    // two cycles after the option page has been cleared
    a_option_mirror: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (erase_go && cur.page == '0)
        |=> ##1 O_OPT_BITS == {2{flash_ctl_pkg::ERASED_BYTE}})
        else $error("option bits not mirrored");

    a_status_shares: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        ##1 O_STATUS[flash_ctl_pkg::ST_UNLOCKED]
            == (cur.state == flash_ctl_pkg::UNLOCKED))
        else $error("status does not track state");

    a_read_protect: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_MEM_RD && I_FROM_DBG && I_READ_PROT)
        |=> O_MEM_RDATA == flash_ctl_pkg::ZERO_BYTE)
        else $error("debugger read leaked data");

    a_row_capture: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        prog_ok |=> O_PROG_ROW == $past(I_MEM_ADDR[flash_ctl_pkg::ROW_SHIFT
                                        +: flash_ctl_pkg::ROW_W]))
        else $error("programmed row not captured");

    a_dbg_can_program: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (cur.state == flash_ctl_pkg::UNLOCKED && I_MEM_PROG && I_FROM_DBG
         && !I_READ_PROT && !sect_locked) |-> prog_ok)
        else $error("debugger program refused");
endmodule

// [flash_ctl_pkg.sv]
// shared constants for the program memory controller
package flash_ctl_pkg;
    // array geometry
    localparam int PAGE_BYTES    = 512;
    localparam int ROW_BYTES     = 64;
    localparam int ROWS_PER_PAGE = 8;
    localparam int BIG_MEM_BYTES = 8192;
    localparam int BIG_SECT      = 1024;
    localparam int SMALL_SECT    = 512;
    localparam int OPT_BYTES     = 2;
    localparam int PAGE_SHIFT    = 9;
    localparam int ROW_SHIFT     = 6;
    localparam int ROW_W         = 3;

    // control values, arbitrary choices
    localparam logic [7:0] KEY_FIRST      = 8'h73;
    localparam logic [7:0] KEY_SECOND     = 8'h8C;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    // status bit positions
    localparam int ST_UNLOCKED = 0;
    localparam int ST_KEY_SEEN = 1;
    localparam int ST_REFUSED  = 2;
    localparam int ST_ERASING  = 3;
    localparam int ST_RD_PROT  = 4;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        LOCKED   = 4'h1,
        KEY_SEEN = 4'h2,
        UNLOCKED = 4'h4,
        ERASING  = 4'h8
    } seq_e;
endpackage

// [flash_cell_array.sv]
// byte-wide flip-flop storage with page erase and bit-clearing program
`timescale 1ns/1ps
module flash_cell_array #(
    parameter int MEM_BYTES = 8192,
    parameter int AW        = $clog2(MEM_BYTES),
    parameter int PW        = AW - flash_ctl_pkg::PAGE_SHIFT
) (
    input  wire logic          clk,
    input  wire logic          i_prog,
    input  wire logic          i_erase,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [PW-1:0] i_page,
    input  wire logic [7:0]    i_wdata,
    output logic      [7:0]    o_rdata,
    output logic      [15:0]   o_opt
);
    typedef struct packed {
        logic [MEM_BYTES-1:0][7:0] mem;
    } cell_s;

    cell_s cur;
    cell_s next_cur;

    // contents are nonvolatile, so reset leaves them alone
    always_comb begin
        next_cur = cur;
        for (int i = 0; i < MEM_BYTES; i++) begin
            if (i_erase && (i / flash_ctl_pkg::PAGE_BYTES) == int'(i_page)) begin
                next_cur.mem[i] = flash_ctl_pkg::ERASED_BYTE;
            end
        end
        // programming can only clear bits, as in a real cell
        if (i_prog) begin
            next_cur.mem[i_addr] = cur.mem[i_addr] & i_wdata;
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    // lowest two bytes feed the option outputs
    assign o_rdata = cur.mem[i_addr];
    assign o_opt   = {cur.mem[1], cur.mem[0]};
endmodule

// [core_dbg_model.sv]
// request model of the processor core and debugger side
`timescale 1ns/1ps
module core_dbg_model #(
    parameter int AW = 13
) (
    input  wire logic          clk,
    output logic               ctl_wr,
    output logic      [7:0]    ctl_wdata,
    output logic               from_dbg,
    output logic               mem_rd,
    output logic               mem_prog,
    output logic      [AW-1:0] mem_addr,
    output logic      [7:0]    mem_wdata
);
    initial begin
        {ctl_wr, mem_rd, mem_prog, from_dbg} = 4'h0;
        {ctl_wdata, mem_wdata, mem_addr} = '0;
    end
    // one strobe after gap idle cycles; buses then show the inverse so a
    // stale value is never mistaken for held data
    task automatic req(input int kind, input logic dbg,
                       input logic [AW-1:0] a, input logic [7:0] d,
                       input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #1;
        from_dbg  = dbg;
        mem_addr  = a;
        ctl_wdata = d;
        mem_wdata = d;
        ctl_wr    = (kind == 0);
        mem_prog  = (kind == 1);
        mem_rd    = (kind == 2);
        @(posedge clk);
        #1;
        {ctl_wr, mem_prog, mem_rd} = 3'h0;
        mem_addr  = ~a;
        ctl_wdata = ~d;
        mem_wdata = ~d;
    endtask
endmodule

// [tb_flash_array_controller.sv]
// self-checking bench for the program memory controller
`timescale 1ns/1ps
module tb_flash_array_controller;
    localparam int AW = 13;
    logic          clk, rst, ctl_wr, from_dbg, mem_rd, mem_prog;
    logic          read_prot, chk_st, rd_d, pg_d, refused;
    logic [AW-1:0] mem_addr;
    logic [AW-1:0] pa [0:9];
    logic [7:0]    ctl_wdata, mem_wdata, sect_wp, status, rdata, v;
    logic [15:0]   opt;
    logic [2:0]    row, last_row;
    logic [7:0]    shadow [0:2047];
    logic [7:0]    rd_q [$];
    logic [7:0]    st_q [$];
    logic [15:0]   opt_q [$];
    logic [2:0]    row_q [$];
    int            num_errors, check_count, seed;

    flash_array_controller dut (
        .I_SYS_CLK   (clk),
        .I_RST       (rst),
        .I_CTL_WR    (ctl_wr),
        .I_CTL_WDATA (ctl_wdata),
        .I_FROM_DBG  (from_dbg),
        .I_MEM_RD    (mem_rd),
        .I_MEM_PROG  (mem_prog),
        .I_MEM_ADDR  (mem_addr),
        .I_MEM_WDATA (mem_wdata),
        .I_SECT_WP   (sect_wp),
        .I_READ_PROT (read_prot),
        .O_STATUS    (status),
        .O_MEM_RDATA (rdata),
        .O_OPT_BITS  (opt),
        .O_PROG_ROW  (row)
    );
    core_dbg_model #(.AW(AW)) host (
        .clk       (clk),
        .ctl_wr    (ctl_wr),
        .ctl_wdata (ctl_wdata),
        .from_dbg  (from_dbg),
        .mem_rd    (mem_rd),
        .mem_prog  (mem_prog),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_st(input logic [7:0] g, e);
        report({8'h00, g}, {8'h00, e});
    endtask
    task automatic cmp_rd(input logic [7:0] g, e);
        report({8'h00, g}, {8'h00, e});
    endtask
    task automatic cmp_opt(input logic [15:0] g, e);
        report(g, e);
    endtask
    task automatic cmp_row(input logic [2:0] g, e);
        report({13'h0, g}, {13'h0, e});
    endtask

    // results settle one cycle after their strobe; sample off the edge
    always @(posedge clk) begin
        rd_d <= mem_rd;
        pg_d <= mem_prog;
    end
    always @(negedge clk) begin
        if (rd_d === 1'b1) cmp_rd(rdata, rd_q.pop_front());
        if (rd_d === 1'b1) cmp_opt(opt, opt_q.pop_front());
        if (pg_d === 1'b1) cmp_row(row, row_q.pop_front());
        if (chk_st) cmp_st(status, st_q.pop_front());
    end

    // random pacing: requests arrive promptly or after a stall
    function automatic int gap();
        return ($random(seed) & 1) * 3;
    endfunction
    task automatic st(input logic [7:0] e);
        st_q.push_back(e | {3'h0, read_prot, 4'h0});
        chk_st = 1'b1;
        @(posedge clk);
        #1;
        chk_st = 1'b0;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d, e);
        host.req(0, 1'b0, a, d, gap());
        st(e);
    endtask
    task automatic unlock();
        wr('0, flash_ctl_pkg::KEY_FIRST, {5'h0, refused, 2'h2});
        wr('0, flash_ctl_pkg::KEY_SECOND, 8'h01);
        refused = 1'b0;
    endtask
    task automatic er(input logic [AW-1:0] a);
        unlock();
        wr(a, flash_ctl_pkg::CMD_PAGE_ERASE, 8'h08);
        st(8'h00);
        for (int i = 0; i < 512; i++) shadow[a[10:9] * 512 + i] = 8'hFF;
    endtask
    task automatic pg(input logic [AW-1:0] a, input logic [7:0] d,
                      input logic dbg, ok);
        if (ok) shadow[a] = shadow[a] & d;
        if (ok) last_row = a[8:6];
        row_q.push_back(last_row);
        host.req(1, dbg, a, d, gap());
        refused = refused | !ok;
        st({5'h0, refused, 2'h1});
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic dbg);
        rd_q.push_back((dbg && read_prot) ? 8'h00 : shadow[a]);
        opt_q.push_back({shadow[1], shadow[0]});
        host.req(2, dbg, a, 8'h00, gap());
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // the tests need a few hundred cycles; far beyond that it has hung
    initial begin
        #(20000 * 5);
        num_errors++;
        results();
    end

    initial begin
        seed = 32'h16d5534f;
        {rst, read_prot, chk_st, refused} = 4'h8;
        sect_wp = 8'h00;
        last_row = 3'h0;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        st(8'h00);
        wr('0, flash_ctl_pkg::KEY_SECOND, 8'h00);
        // low nibble cleared, so never a key or the erase command
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed)) & 8'hF0;
            wr('0, v, 8'h00);
            wr('0, flash_ctl_pkg::KEY_FIRST, 8'h02);
            wr('0, v, 8'h00);
            unlock();
            wr('0, v, 8'h00);
        end
        $display("test relock done");
        for (int p = 0; p < 4; p++) er(AW'(p * 549));
        for (int p = 0; p < 4; p++) begin
            rd(AW'(p * 512), 1'b0);
            rd(AW'(p * 512 + 511), 1'b1);
        end
        $display("test erase done");
        unlock();
        for (int i = 0; i < 10; i++) begin
            pa[i] = AW'((i % 2) * 512 + (i % 8) * 64 + (i * 13) % 64);
            if (i < 2) pa[i] = AW'(i);
            pg(pa[i], 8'($random(seed)), i[0], 1'b1);
        end
        pg(AW'(1029), 8'h3C, 1'b0, 1'b1);
        wr('0, 8'h00, 8'h00);
        er(AW'(600));
        for (int i = 0; i < 10; i++) rd(pa[i], 1'b0);
        $display("test program done");
        sect_wp = 8'h02;
        unlock();
        pg(AW'(1029), 8'h00, 1'b0, 1'b0);
        pg(AW'(1700), 8'h00, 1'b1, 1'b0);
        pg(AW'(700), 8'h0F, 1'b1, 1'b1);
        wr(AW'(1029), flash_ctl_pkg::CMD_PAGE_ERASE, 8'h04);
        refused = 1'b1;
        rd(AW'(1029), 1'b0);
        rd(AW'(1700), 1'b0);
        sect_wp = 8'h00;
        read_prot = 1'b1;
        rd(AW'(700), 1'b1);
        rd(AW'(700), 1'b0);
        // debugger under read protection may neither program nor erase
        unlock();
        pg(AW'(700), 8'h00, 1'b1, 1'b0);
        host.req(0, 1'b1, AW'(700), flash_ctl_pkg::CMD_PAGE_ERASE,
                 gap());
        st(8'h04);
        rd(AW'(700), 1'b0);
        st({5'h0, refused, 2'h0});
        $display("test protect done");
        results();
    end
endmodule
